// ===== bench/qbtp_far_bus.sv
// Far side of the shared bus: another open-collector sinker and the pull-up.
`timescale 1ns/1ps
`default_nettype none
module qbtp_far_bus
(
	input wire logic [3:0] i_dut_sink, // Lines our device pulls low.
	input wire logic [3:0] i_far_sink, // Lines the other transceiver pulls low.
	output logic [3:0] o_line // Resolved level seen by every receiver.
);
	// A line is low if anyone sinks it, else the pull-up wins, so it is never left floating.
	assign o_line = ~(i_dut_sink | i_far_sink);
endmodule : qbtp_far_bus
`default_nettype wire

// ===== bench/qbtp_transceiver_chk.sv
// Port checker for the quad bus transceiver, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module qbtp_chk
	import qbtp_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic [3:0] i_first_word_in,
	input wire logic [3:0] i_second_word_in,
	input wire logic i_input_pick,
	input wire logic i_driver_clock,
	input wire logic i_bus_drive_disable_n,
	input wire logic i_receiver_hold,
	input wire logic i_receiver_output_off_n,
	input wire logic [3:0] i_bus_in,
	input wire qbtp_req_t i_req,
	input wire qbtp_bus_t o_bus,
	input wire qbtp_recv_t o_recv,
	input wire logic o_parity,
	input wire logic [31:0] o_rdata
);
	// Picked word one edge late, which keeps the properties free of past calls on expressions.
	logic [3:0] pk;
	always_ff @(posedge i_clk)
	begin
		pk <= i_input_pick ? i_second_word_in : i_first_word_in;
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	chk_pick_parity: assert property (!i_bus_drive_disable_n |=> o_parity == ~^pk)
		else $error("generate parity wrong");
	chk_check_parity: assert property (i_bus_drive_disable_n |=> o_parity == ~^o_recv.data)
		else $error("check parity wrong");
	chk_load_edge: assert property (
		$rose(i_driver_clock) && !i_bus_drive_disable_n && !$past(i_sys_rst) |=> o_bus.oe == pk)
		else $error("driver load wrong");
	chk_drv_keep: assert property (
		!$rose(i_driver_clock) && $stable(i_bus_drive_disable_n) |=> $stable(o_bus.oe))
		else $error("driver changed without edge");
	chk_drv_off: assert property (i_bus_drive_disable_n |=> o_bus.oe == 4'h0)
		else $error("driver not released");
	chk_open_coll: assert property (o_bus.out == 4'h0)
		else $error("bus driven high");
	chk_latch_follow: assert property (!i_receiver_hold |=> o_recv.data == ~$past(i_bus_in))
		else $error("latch not following");
	chk_latch_keep: assert property (i_receiver_hold && !$past(i_sys_rst) |=> $stable(o_recv.data))
		else $error("latch not holding");
	chk_recv_float: assert property (1'b1 |=> o_recv.oe == {4{!$past(i_receiver_output_off_n)}})
		else $error("receiver enable wrong");
	chk_rdata_idle: assert property (!i_req.rd |=> o_rdata == 32'h0000_0000)
		else $error("read data outside slot");
endmodule : qbtp_chk
bind qbtp_transceiver qbtp_chk u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
	.i_first_word_in(i_first_word_in), .i_second_word_in(i_second_word_in),
	.i_input_pick(i_input_pick), .i_driver_clock(i_driver_clock),
	.i_bus_drive_disable_n(i_bus_drive_disable_n), .i_receiver_hold(i_receiver_hold),
	.i_receiver_output_off_n(i_receiver_output_off_n), .i_bus_in(i_bus_in), .i_req(i_req),
	.o_bus(o_bus), .o_recv(o_recv), .o_parity(o_parity), .o_rdata(o_rdata));
`default_nettype wire

// ===== bench/quad_bus_transceiver_parity_tb.sv
// Self-checking bench for the quad bus transceiver with parity.
`timescale 1ns/1ps
`default_nettype none
module quad_bus_transceiver_parity_tb;
	import qbtp_pkg::*;
	logic i_clk = 0, rst = 1, pick = 0, dclk = 0, dis_n = 1, hold = 0, off_n = 0, par, irq;
	logic [3:0] fw = 0, sw = 0, far = 0; // Driver words and the other sinker.
	wire [3:0] line; // Resolved bus.
	qbtp_req_t req = '0;
	qbtp_bus_t bus;
	qbtp_recv_t rcv;
	logic [31:0] rdata, d;
	int n_mismatch = 0, check_count = 0, cyc = 0;
	qbtp_transceiver u_dut (.i_clk(i_clk), .i_sys_rst(rst), .i_first_word_in(fw),
		.i_second_word_in(sw), .i_input_pick(pick), .i_driver_clock(dclk),
		.i_bus_drive_disable_n(dis_n), .i_receiver_hold(hold), .i_receiver_output_off_n(off_n),
		.i_bus_in(line), .i_req(req), .o_bus(bus), .o_recv(rcv), .o_parity(par),
		.o_rdata(rdata), .o_irq(irq));
	qbtp_far_bus u_far (.i_dut_sink(bus.oe), .i_far_sink(far), .o_line(line));
	// Free-running 100 MHz clock.
	initial
	begin
		forever #5 i_clk = ~i_clk;
	end
	task close_out;
		$display("mismatches %0d of %0d checks", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : close_out
	task cmp(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask : cmp
	// Three edges cover every registered stage from pin to parity.
	task settle;
		repeat (3) @(posedge i_clk);
		#1;
	endtask : settle
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge i_clk) req <= '{a, v, 1'b1, 1'b0};
		@(posedge i_clk) req.wr <= 1'b0;
	endtask : wr
	// Read data stand only in the cycle after the strobe, so they are taken there.
	task rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge i_clk) req <= '{a, 32'h0000_0000, 1'b0, 1'b1};
		@(posedge i_clk) req.rd <= 1'b0;
		#1 v = rdata;
	endtask : rd
	// Driver clock stays low one cycle and high one cycle so both levels are seen.
	task ld(input logic p, input logic [3:0] a, input logic [3:0] b);
		@(posedge i_clk)
		begin
			pick <= p;
			fw <= a;
			sw <= b;
		end
		@(posedge i_clk) dclk <= 1'b1;
		@(posedge i_clk) dclk <= 1'b0;
		settle();
	endtask : ld
	// Main sequence; drivers stay off until the register holds known data.
	initial
	begin
		repeat (6) @(posedge i_clk);
		rst <= 1'b0;
		// A quiet bus right after reset must not look like any event.
		rd(8'h00, d);
		cmp(d, 32'h0000_0000);
		ld(1'b0, 4'h5, 4'hA);
		cmp(bus.oe, 4'h0);
		cmp(rcv.oe, 4'hF);
		@(posedge i_clk) dis_n <= 1'b0;
		settle();
		cmp(bus.oe, 4'h5);
		cmp(line, 4'hA);
		cmp(rcv.data, 4'h5);
		cmp(par, 1'b1);
		ld(1'b1, 4'h5, 4'h7);
		cmp(bus.oe, 4'h7);
		cmp(par, 1'b0);
		@(posedge i_clk) far <= 4'h9;
		settle();
		cmp(rcv.data, 4'hF);
		@(posedge i_clk) dis_n <= 1'b1;
		settle();
		cmp(rcv.data, 4'h9);
		cmp(par, 1'b1);
		@(posedge i_clk)
		begin
			hold <= 1'b1;
			far <= 4'h0;
		end
		settle();
		cmp(rcv.data, 4'h9);
		@(posedge i_clk) hold <= 1'b0;
		settle();
		cmp(rcv.data, 4'h0);
		@(posedge i_clk) off_n <= 1'b1;
		settle();
		cmp(rcv.oe, 4'h0);
		wr(8'h08, 32'h0000_0001);
		rd(8'h08, d);
		cmp(d, 32'h0000_0001);
		// Loads, the latch closing and the parity rise on entering check mode.
		rd(8'h00, d);
		cmp(d, 32'h0000_0007);
		cmp(irq, 1'b1);
		wr(8'h04, 32'h0000_0007);
		rd(8'h00, d);
		cmp(d, 32'h0000_0000);
		cmp(irq, 1'b0);
		rd(8'h10, d);
		cmp(d, 32'h0000_0000);
		ld(1'b0, 4'h3, 4'h0);
		cmp(irq, 1'b1);
		// State view: check mode, parity high, latches empty, register holds 3.
		rd(8'h0C, d);
		cmp(d, 32'h0000_0303);
		close_out();
	end
	// The whole sequence needs about sixty-five cycles; the ceiling leaves ample margin.
	always @(posedge i_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			n_mismatch++;
			close_out();
		end
	end
endmodule : quad_bus_transceiver_parity_tb
`default_nettype wire

// ===== verilog/qbtp_map.svh
// Constants for the quad bus transceiver with parity.
`ifndef QBTP_MAP_SVH
`define QBTP_MAP_SVH
// Register offsets, byte addresses of aligned words.
`define QBTP_STATUS_OFS 8'h00
`define QBTP_CLEAR_OFS 8'h04
`define QBTP_ENABLE_OFS 8'h08
`define QBTP_STATE_OFS 8'h0C
// Event bit positions in status, clear and enable, and the event count.
`define QBTP_EV_LOAD 0
`define QBTP_EV_CLOSE 1
`define QBTP_EV_PAR 2
`define QBTP_EV_W 3
// Field positions in the state register.
`define QBTP_ST_DRV 0
`define QBTP_ST_LAT 4
`define QBTP_ST_PAR 8
`define QBTP_ST_MODE 9
// Reset values.
`define QBTP_ENABLE_RST 3'h0
`define QBTP_STATUS_RST 3'h0
`endif

// ===== verilog/qbtp_pkg.sv
// Types shared by the quad bus transceiver with parity.
package qbtp_pkg;
	// One group of open-collector bus pins.
	typedef struct packed {
		logic [3:0] out;
		logic [3:0] oe;
	} qbtp_bus_t;
	// One group of three-state receiver pins.
	typedef struct packed {
		logic [3:0] data;
		logic [3:0] oe;
	} qbtp_recv_t;
	// Register port request from software.
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} qbtp_req_t;
endpackage : qbtp_pkg

// ===== verilog/qbtp_transceiver.sv
// Quad bus transceiver with driver register, receiver latches and parity.
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "qbtp_map.svh"
module qbtp_transceiver
	import qbtp_pkg::*;
#(
	parameter int WIDTH = 4
)
(
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic [3:0] i_first_word_in,
	input wire logic [3:0] i_second_word_in,
	input wire logic i_input_pick,
	input wire logic i_driver_clock,
	input wire logic i_bus_drive_disable_n,
	input wire logic i_receiver_hold,
	input wire logic i_receiver_output_off_n,
	input wire logic [3:0] i_bus_in,
	input wire qbtp_req_t i_req,
	output var qbtp_bus_t o_bus,
	output var qbtp_recv_t o_recv,
	output logic o_parity,
	output logic [31:0] o_rdata,
	output logic o_irq
);

	// The slice is four bits wide; other widths are refused.
	if (WIDTH != 4)
	begin : g_width_check
		$error("qbtp_transceiver serves only WIDTH 4.");
	end

	// Returns high when the four bits hold an even count of ones.
	function automatic logic odd_parity(input logic [3:0] bits);
		odd_parity = ~^bits;
	endfunction : odd_parity

	// Driver register contents; never reset.
	logic [3:0] drv_reg;
	logic [3:0] next_drv_reg;
	// Previous driver clock sample, for edge detection.
	logic drv_clk_q;
	logic next_drv_clk_q;
	// Receiver latch contents; never reset.
	logic [3:0] lat_reg;
	logic [3:0] next_lat_reg;
	// Previous receiver hold sample.
	logic hold_q;
	logic next_hold_q;
	// Word chosen by the input multiplexers.
	logic [3:0] picked;
	// One-cycle pulse on a driver clock rise.
	logic drv_rise;

	// The driver clock is sampled as a plain input, so a load
	// lands one system clock after the rise is seen. The
	// driver clock must stay in each level for at least one
	// system clock or an edge is missed.
	always_comb
	begin
		// Shared select steers all four multiplexers.
		if (i_input_pick)
		begin
			picked = i_second_word_in;
		end
		else
		begin
			picked = i_first_word_in;
		end
		next_drv_clk_q = i_driver_clock;
		drv_rise = i_driver_clock & ~drv_clk_q;
		// One flop per bit, all on the same edge.
		if (drv_rise)
		begin
			next_drv_reg = picked;
		end
		else
		begin
			next_drv_reg = drv_reg;
		end
	end

	// Driver register has no reset; the edge detector does.
	always_ff @(posedge i_clk)
	begin
		drv_reg <= next_drv_reg;
		if (i_sys_rst)
		begin
			// Starting high keeps a high driver clock at reset
			// from being taken for a rising edge.
			drv_clk_q <= 1'b1;
		end
		else
		begin
			drv_clk_q <= next_drv_clk_q;
		end
	end

	// Receiver latch next value.
	always_comb
	begin
		next_hold_q = i_receiver_hold;
		if (i_receiver_hold)
		begin
			// Closed: keep the value, whatever the bus does.
			next_lat_reg = lat_reg;
		end
		else
		begin
			// Open: follow the inverted bus, own drive included.
			next_lat_reg = ~i_bus_in;
		end
	end

	// Latch contents carry no reset; the hold sample does.
	always_ff @(posedge i_clk)
	begin
		lat_reg <= next_lat_reg;
		if (i_sys_rst)
		begin
			hold_q <= 1'b0;
		end
		else
		begin
			hold_q <= next_hold_q;
		end
	end

	// Pin outputs, all registered.
	qbtp_bus_t next_bus;
	qbtp_recv_t next_recv;
	logic next_parity;

	// Pin values are computed from the next register contents
	// so that each pin changes on the same edge as its source.
	always_comb
	begin
		// Open collector: the pin only ever sinks.
		next_bus.out = 4'h0;
		// A stored one sinks its line while driving is on.
		if (i_bus_drive_disable_n)
		begin
			next_bus.oe = 4'h0;
		end
		else
		begin
			next_bus.oe = next_drv_reg;
		end
		next_recv.data = next_lat_reg;
		// Receiver outputs float while output off is high.
		next_recv.oe = {4{~i_receiver_output_off_n}};
		// Generate from the picked word, or check the latches.
		if (i_bus_drive_disable_n)
		begin
			next_parity = odd_parity(next_lat_reg);
		end
		else
		begin
			next_parity = odd_parity(picked);
		end
	end

	// Enables reset low so nothing is driven out of reset.
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			o_bus <= '0;
			o_recv <= '0;
			o_parity <= 1'b0;
		end
		else
		begin
			o_bus <= next_bus;
			o_recv <= next_recv;
			o_parity <= next_parity;
		end
	end

	// Sticky event status and its enable mask.
	logic [2:0] status;
	logic [2:0] next_status;
	logic [2:0] enable;
	logic [2:0] next_enable;
	// Events raised this cycle.
	logic [2:0] events;
	// Previous check-mode parity flag, for edge detection.
	logic chk_q;
	logic next_chk_q;
	logic [31:0] next_rdata;
	logic next_irq;

	// Events, register writes, and the read mux.
	always_comb
	begin
		events = 3'h0;
		// A driver register load.
		events[`QBTP_EV_LOAD] = drv_rise;
		// The receiver latches just closed.
		events[`QBTP_EV_CLOSE] = i_receiver_hold & ~hold_q;
		// Parity output rose while checking received data.
		next_chk_q = i_bus_drive_disable_n & next_parity;
		events[`QBTP_EV_PAR] = next_chk_q & ~chk_q;
		next_enable = enable;
		next_status = status;
		if (i_req.wr && i_req.addr == `QBTP_CLEAR_OFS)
		begin
			// Write one to clear.
			next_status = status & ~i_req.wdata[2:0];
		end
		else if (i_req.wr && i_req.addr == `QBTP_ENABLE_OFS)
		begin
			next_enable = i_req.wdata[2:0];
		end
		// A new event wins over a clear in the same cycle.
		next_status = next_status | events;
		next_irq = |(next_status & next_enable);
		next_rdata = 32'h0000_0000;
		if (!i_req.rd)
		begin
			next_rdata = 32'h0000_0000;
		end
		else if (i_req.addr == `QBTP_STATUS_OFS)
		begin
			next_rdata[2:0] = status;
		end
		else if (i_req.addr == `QBTP_ENABLE_OFS)
		begin
			next_rdata[2:0] = enable;
		end
		else if (i_req.addr == `QBTP_STATE_OFS)
		begin
			// Live view of the driver, latch and parity state.
			next_rdata[`QBTP_ST_DRV +: 4] = drv_reg;
			next_rdata[`QBTP_ST_LAT +: 4] = lat_reg;
			next_rdata[`QBTP_ST_PAR] = o_parity;
			next_rdata[`QBTP_ST_MODE] = i_bus_drive_disable_n;
		end
		else
		begin
			// Clear and unmapped words read as zero.
			next_rdata = 32'h0000_0000;
		end
	end

	// Register file and interrupt flops.
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			status <= `QBTP_STATUS_RST;
			enable <= `QBTP_ENABLE_RST;
			// A released bus latches as all zeros, whose parity is high,
			// so starting high keeps a false parity event out of reset.
			chk_q <= 1'b1;
			o_rdata <= 32'h0000_0000;
			o_irq <= 1'b0;
		end
		else
		begin
			status <= next_status;
			enable <= next_enable;
			chk_q <= next_chk_q;
			o_rdata <= next_rdata;
			o_irq <= next_irq;
		end
	end

endmodule : qbtp_transceiver
`default_nettype wire
